// ---- rtl/mif_cfg.svh ----
// Purpose: Register indices, field positions, reset values and timing counts of the motion interrupt block
// Assumes: 32-bit register bus; byte address of a register is four times its index
// Notes:   Definitions only
`ifndef MIF_CFG_SVH
`define MIF_CFG_SVH

// Register indices
`define MIF_IDX_THR_X      6'h20
`define MIF_IDX_THR_Y      6'h21
`define MIF_IDX_THR_Z      6'h22
`define MIF_IDX_STREAM_SEL 6'h23
`define MIF_IDX_FRAME_SYNC_INPUT_STAT 6'h36
`define MIF_IDX_PIN_CFG    6'h37
`define MIF_IDX_SRC_EN     6'h38
`define MIF_IDX_MP_STAT    6'h39
`define MIF_IDX_MAIN_STAT  6'h3A

// Stream select fields
`define MIF_SEL_TEMP  7
`define MIF_SEL_GX    6
`define MIF_SEL_GY    5
`define MIF_SEL_GZ    4
`define MIF_SEL_ACCEL 3

// Pin configuration fields
`define MIF_PIN_POL     7
`define MIF_PIN_OPEN    6
`define MIF_PIN_LATCH   5
`define MIF_PIN_RDCLR   4
`define MIF_PIN_FS_POL  3
`define MIF_PIN_FS_EN   2

// Source enable fields
`define MIF_EN_WOM_HI 7
`define MIF_EN_WOM_LO 5
`define MIF_EN_OVF    4
`define MIF_EN_GDRV   2
`define MIF_EN_MP     1
`define MIF_EN_DRDY   0
`define MIF_WOM_ON    3'h7

// Main status fields and frame-sync status flag
`define MIF_ST_OVF  4
`define MIF_ST_GDRV 2
`define MIF_ST_MP   1
`define MIF_ST_DRDY 0
`define MIF_FS_FLAG 7

// Reset values
`define MIF_RST_BYTE 8'h00

// AXI responses
`define MIF_RESP_OKAY   2'h0
`define MIF_RESP_SLVERR 2'h2

// Timing
`define MIF_CLK_PERIOD_NS 20
`define MIF_PULSE_NS      50000
`define MIF_PULSE_CYC     (`MIF_PULSE_NS / `MIF_CLK_PERIOD_NS)

`endif

// ---- rtl/mif_pkg.sv ----
// Purpose: Types shared by the motion interrupt block
// Assumes: Constants live in mif_cfg.svh
// Notes:   One-hot state codes
package mif_pkg;

  typedef enum logic [1:0] {
    MIF_SER_IDLE = 2'h1,
    MIF_SER_EMIT = 2'h2
  } mif_ser_state_type;

  typedef logic [15:0] mif_word_type;

endpackage

// ---- rtl/mif_top.sv ----
// Purpose: Motion sensor interrupt, wake-on-motion and sample buffer stream configuration
// Assumes: All inputs synchronous to REF_CLK; buffer and sensors live outside
// Notes:   Registers over AXI4-Lite, byte address = 4 * index
// Function
// - Three 8-bit writable wake-on-motion thresholds, one per accelerometer axis.
// - Temperature enable bit appends temperature high and low bytes each sample.
// - Gyro X, Y, Z enable bits each append that axis's two bytes.
// - Enabled streams are buffered even when their measurement path is in standby.
// - Accelerometer enable bit appends all six accelerometer bytes each sample.
// - Frame-sync status bit sets on frame-sync interrupt, clears on read.
// - Polarity bit: one makes interrupt pin active low, zero active high.
// - Drive bit: one makes interrupt pin open drain, zero push-pull.
// - Latch bit holds pin until status cleared, else emits 50us pulse.
// - Clear-policy bit lets any read clear status, else each status register clears only on a read of itself.
// - Frame-sync polarity bit selects active low or active high input.
// - Frame-sync enable lets a transition to active level raise an interrupt.
// - Wake-on-motion enabled only by code 111, disabled by 000.
// - Overflow enable bit gates buffer overflow onto the interrupt pin.
// - Gyro drive-ready enable bit gates that interrupt onto the pin.
// - Motion-processor and data-ready enable bits gate their interrupts onto the pin.
// - Six motion-processor flags in a status register, cleared by reading it.
// - Main status overflow bit sets on overflow, clears on read.
// - Main status data-ready bit sets on data ready, clears on read.
// - Wake-on-motion shows as 111 in main status upper bits, cleared on read.
`timescale 1ns/1ps
`default_nettype none
`include "mif_cfg.svh"

module mif_top #(
  parameter int PULSE_CYC = `MIF_PULSE_CYC
) (
  input  wire logic        REF_CLK,
  input  wire logic        RESET,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic        SAMPLE_STROBE,
  input  wire logic [15:0] ACCEL_X,
  input  wire logic [15:0] ACCEL_Y,
  input  wire logic [15:0] ACCEL_Z,
  input  wire logic [15:0] TEMP_DATA,
  input  wire logic [15:0] GYRO_X,
  input  wire logic [15:0] GYRO_Y,
  input  wire logic [15:0] GYRO_Z,
  input  wire logic        BUF_OVERFLOW,
  input  wire logic        GYRO_DRIVE_READY,
  input  wire logic [5:0]  MOTION_PROCESSOR_EVENTS,
  input  wire logic        FRAME_SYNC_INPUT,
  output logic             BUF_WR_VALID,
  output logic [7:0]       BUF_WR_DATA,
  output logic             IRQ_OUTPUT_PIN_O,
  output logic             IRQ_OUTPUT_PIN_OE
);

  // Register file
  logic [7:0] motion_thresh_q [3];
  logic [7:0] stream_sel_q;
  logic [7:2] pin_cfg_q;
  logic [2:0] motion_wake_irq_enable_q;
  logic [4:0] src_en_low_q;
  logic       frame_sync_irq_flag_q;
  logic [5:0] motion_processor_irq_flags_q;
  logic       motion_wake_irq_flag_q;
  logic       overflow_irq_flag_q;
  logic       gyro_drive_flag_q;
  logic       mp_flag_q;
  logic       data_ready_flag_q;

  // Bus state
  logic       aw_got_q;
  logic       w_got_q;
  logic [5:0] wr_idx_q;
  logic [7:0] wr_byte_q;
  logic       wr_lane_q;
  logic       wr_go;
  logic       wr_hit;
  logic       rd_hs;
  logic [5:0] rd_idx;
  logic [7:0] rd_byte;
  logic       rd_hit;

  // Event and pin state
  logic        frame_sync_prev_q;
  logic        frame_sync_active;
  logic        frame_sync_set;
  logic        motion_wake_set;
  logic        motion_wake_on;
  logic        rd_clear_any;
  logic        clr_main;
  logic        clr_frame_sync_input;
  logic        clr_mp;
  logic        irq_pending;
  logic        irq_new_event;
  logic        irq_active;
  logic        irq_level;
  logic [15:0] pulse_cnt_q;
  logic [15:0] accel_prev_q [3];
  logic        accel_prev_valid_q;
  logic [2:0]  axis_over;

  // Serializer state
  mif_pkg::mif_ser_state_type state_q;
  mif_pkg::mif_word_type      words_q [7];
  logic [6:0]                 mask_q;
  logic                       half_q;
  logic [2:0]                 next_idx;
  logic                       mask_any;

  // ---------------- AXI4-Lite write path ----------------
  assign wr_go = aw_got_q & w_got_q & ~S_AXI_BVALID;

  always_comb begin
    unique case (wr_idx_q)
      `MIF_IDX_THR_X, `MIF_IDX_THR_Y, `MIF_IDX_THR_Z, `MIF_IDX_STREAM_SEL,
      `MIF_IDX_FRAME_SYNC_INPUT_STAT, `MIF_IDX_PIN_CFG, `MIF_IDX_SRC_EN, `MIF_IDX_MP_STAT,
      `MIF_IDX_MAIN_STAT: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      S_AXI_AWREADY <= 1'b1;
      aw_got_q      <= 1'b0;
      wr_idx_q      <= 6'h00;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      S_AXI_AWREADY <= 1'b0;
      aw_got_q      <= 1'b1;
      wr_idx_q      <= S_AXI_AWADDR[7:2];
    end else if (wr_go) begin
      aw_got_q <= 1'b0;
    end else if (S_AXI_BVALID && S_AXI_BREADY) begin
      S_AXI_AWREADY <= 1'b1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      S_AXI_WREADY <= 1'b1;
      w_got_q      <= 1'b0;
      wr_byte_q    <= 8'h00;
      wr_lane_q    <= 1'b0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      S_AXI_WREADY <= 1'b0;
      w_got_q      <= 1'b1;
      wr_byte_q    <= S_AXI_WDATA[7:0];
      wr_lane_q    <= S_AXI_WSTRB[0];
    end else if (wr_go) begin
      w_got_q <= 1'b0;
    end else if (S_AXI_BVALID && S_AXI_BREADY) begin
      S_AXI_WREADY <= 1'b1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `MIF_RESP_OKAY;
    end else if (wr_go) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= wr_hit ? `MIF_RESP_OKAY : `MIF_RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // Writable registers; status registers ignore writes
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      motion_thresh_q[0]       <= `MIF_RST_BYTE;
      motion_thresh_q[1]       <= `MIF_RST_BYTE;
      motion_thresh_q[2]       <= `MIF_RST_BYTE;
      stream_sel_q             <= `MIF_RST_BYTE;
      pin_cfg_q                <= 6'h00;
      motion_wake_irq_enable_q <= 3'h0;
      src_en_low_q             <= 5'h00;
    end else if (wr_go && wr_lane_q) begin
      unique case (wr_idx_q)
        `MIF_IDX_THR_X:      motion_thresh_q[0] <= wr_byte_q;
        `MIF_IDX_THR_Y:      motion_thresh_q[1] <= wr_byte_q;
        `MIF_IDX_THR_Z:      motion_thresh_q[2] <= wr_byte_q;
        `MIF_IDX_STREAM_SEL: stream_sel_q       <= {wr_byte_q[7:3], 3'h0};
        `MIF_IDX_PIN_CFG:    pin_cfg_q          <= wr_byte_q[7:2];
        `MIF_IDX_SRC_EN: begin
          motion_wake_irq_enable_q <= wr_byte_q[`MIF_EN_WOM_HI:`MIF_EN_WOM_LO];
          src_en_low_q             <= wr_byte_q[4:0];
        end
        default: ;
      endcase
    end
  end

  // ---------------- AXI4-Lite read path ----------------
  assign rd_hs  = S_AXI_ARVALID & S_AXI_ARREADY;
  assign rd_idx = S_AXI_ARADDR[7:2];

  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    unique case (rd_idx)
      `MIF_IDX_THR_X:      rd_byte = motion_thresh_q[0];
      `MIF_IDX_THR_Y:      rd_byte = motion_thresh_q[1];
      `MIF_IDX_THR_Z:      rd_byte = motion_thresh_q[2];
      `MIF_IDX_STREAM_SEL: rd_byte = stream_sel_q;
      `MIF_IDX_FRAME_SYNC_INPUT_STAT: rd_byte = {frame_sync_irq_flag_q, 7'h00};
      `MIF_IDX_PIN_CFG:    rd_byte = {pin_cfg_q, 2'h0};
      `MIF_IDX_SRC_EN:     rd_byte = {motion_wake_irq_enable_q, src_en_low_q};
      `MIF_IDX_MP_STAT:    rd_byte = {2'h0, motion_processor_irq_flags_q};
      `MIF_IDX_MAIN_STAT:  rd_byte = {{3{motion_wake_irq_flag_q}}, overflow_irq_flag_q, 1'b0,
                                      gyro_drive_flag_q, mp_flag_q, data_ready_flag_q};
      default:             rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= `MIF_RESP_OKAY;
    end else if (rd_hs) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RDATA   <= {24'h000000, rd_byte};
      S_AXI_RRESP   <= rd_hit ? `MIF_RESP_OKAY : `MIF_RESP_SLVERR;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
    end
  end

  // ---------------- Status flags ----------------
  // A read clears the value it returned; an event in the same cycle survives
  assign rd_clear_any = rd_hs & pin_cfg_q[`MIF_PIN_RDCLR];
  assign clr_main     = rd_clear_any | (rd_hs & (rd_idx == `MIF_IDX_MAIN_STAT));
  assign clr_frame_sync_input    = rd_clear_any | (rd_hs & (rd_idx == `MIF_IDX_FRAME_SYNC_INPUT_STAT));
  assign clr_mp       = rd_clear_any | (rd_hs & (rd_idx == `MIF_IDX_MP_STAT));

  assign frame_sync_active = FRAME_SYNC_INPUT ^ pin_cfg_q[`MIF_PIN_FS_POL];
  assign frame_sync_set    = pin_cfg_q[`MIF_PIN_FS_EN] & frame_sync_active
                             & ~frame_sync_prev_q;

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      frame_sync_prev_q <= 1'b1;
    end else begin
      frame_sync_prev_q <= frame_sync_active;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      frame_sync_irq_flag_q <= 1'b0;
    end else begin
      frame_sync_irq_flag_q <= frame_sync_set | (frame_sync_irq_flag_q & ~clr_frame_sync_input);
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      motion_processor_irq_flags_q <= 6'h00;
    end else begin
      motion_processor_irq_flags_q <= MOTION_PROCESSOR_EVENTS
                                      | (motion_processor_irq_flags_q & ~{6{clr_mp}});
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      motion_wake_irq_flag_q <= 1'b0;
      overflow_irq_flag_q    <= 1'b0;
      gyro_drive_flag_q      <= 1'b0;
      mp_flag_q              <= 1'b0;
      data_ready_flag_q      <= 1'b0;
    end else begin
      motion_wake_irq_flag_q <= motion_wake_set | (motion_wake_irq_flag_q & ~clr_main);
      overflow_irq_flag_q    <= BUF_OVERFLOW | (overflow_irq_flag_q & ~clr_main);
      gyro_drive_flag_q      <= GYRO_DRIVE_READY | (gyro_drive_flag_q & ~clr_main);
      mp_flag_q              <= (|MOTION_PROCESSOR_EVENTS) | (mp_flag_q & ~clr_main);
      data_ready_flag_q      <= SAMPLE_STROBE | (data_ready_flag_q & ~clr_main);
    end
  end

  // ---------------- Wake on motion ----------------
  // Other codes than all-ones count as disabled
  assign motion_wake_on = (motion_wake_irq_enable_q == `MIF_WOM_ON);

  always_comb begin
    logic signed [16:0] diff;
    logic        [16:0] mag;
    diff      = 17'sh00000;
    mag       = 17'h00000;
    axis_over = 3'h0;
    for (int i = 0; i < 3; i++) begin
      diff = 17'($signed(words_in(i))) - 17'($signed(accel_prev_q[i]));
      mag  = diff[16] ? 17'(-diff) : 17'(diff);
      axis_over[i] = (mag > {9'h000, motion_thresh_q[i]});
    end
  end

  function automatic logic [15:0] words_in(input int axis);
    unique case (axis)
      0:       words_in = ACCEL_X;
      1:       words_in = ACCEL_Y;
      default: words_in = ACCEL_Z;
    endcase
  endfunction

  assign motion_wake_set = SAMPLE_STROBE & accel_prev_valid_q & motion_wake_on & (|axis_over);

  // First sample after reset has no reference and raises no event
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      accel_prev_q[0]    <= 16'h0000;
      accel_prev_q[1]    <= 16'h0000;
      accel_prev_q[2]    <= 16'h0000;
      accel_prev_valid_q <= 1'b0;
    end else if (SAMPLE_STROBE) begin
      accel_prev_q[0]    <= ACCEL_X;
      accel_prev_q[1]    <= ACCEL_Y;
      accel_prev_q[2]    <= ACCEL_Z;
      accel_prev_valid_q <= 1'b1;
    end
  end

  // ---------------- Interrupt pin ----------------
  assign irq_pending = (motion_wake_irq_flag_q & motion_wake_on)
                     | (overflow_irq_flag_q & src_en_low_q[`MIF_EN_OVF])
                     | (gyro_drive_flag_q & src_en_low_q[`MIF_EN_GDRV])
                     | (mp_flag_q & src_en_low_q[`MIF_EN_MP])
                     | (data_ready_flag_q & src_en_low_q[`MIF_EN_DRDY])
                     | frame_sync_irq_flag_q;

  assign irq_new_event = (motion_wake_set & motion_wake_on)
                       | (BUF_OVERFLOW & src_en_low_q[`MIF_EN_OVF])
                       | (GYRO_DRIVE_READY & src_en_low_q[`MIF_EN_GDRV])
                       | ((|MOTION_PROCESSOR_EVENTS) & src_en_low_q[`MIF_EN_MP])
                       | (SAMPLE_STROBE & src_en_low_q[`MIF_EN_DRDY])
                       | frame_sync_set;

  // Pulse restarts on each new event, so bursts stretch one pulse
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      pulse_cnt_q <= 16'h0000;
    end else if (irq_new_event) begin
      pulse_cnt_q <= 16'(PULSE_CYC);
    end else if (pulse_cnt_q != 16'h0000) begin
      pulse_cnt_q <= pulse_cnt_q - 16'h0001;
    end
  end

  assign irq_active = pin_cfg_q[`MIF_PIN_LATCH] ? irq_pending : (pulse_cnt_q != 16'h0000);
  assign irq_level  = irq_active ^ pin_cfg_q[`MIF_PIN_POL];

  // Open drain only pulls low; a high level releases the pin
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      IRQ_OUTPUT_PIN_O  <= 1'b0;
      IRQ_OUTPUT_PIN_OE <= 1'b1;
    end else if (pin_cfg_q[`MIF_PIN_OPEN]) begin
      IRQ_OUTPUT_PIN_O  <= 1'b0;
      IRQ_OUTPUT_PIN_OE <= ~irq_level;
    end else begin
      IRQ_OUTPUT_PIN_O  <= irq_level;
      IRQ_OUTPUT_PIN_OE <= 1'b1;
    end
  end

  // ---------------- Sample buffer serializer ----------------
  // Word order: accel X, Y, Z, temperature, gyro X, Y, Z; high byte first.
  // Streams are not gated by sensor standby: the selected bytes are always sent.
  always_comb begin
    next_idx = 3'h0;
    for (int i = 6; i >= 0; i--) begin
      if (mask_q[i]) begin
        next_idx = 3'(i);
      end
    end
  end

  assign mask_any = |mask_q;

  // A strobe while a frame is still being sent is dropped
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      state_q      <= mif_pkg::MIF_SER_IDLE;
      mask_q       <= 7'h00;
      half_q       <= 1'b0;
      BUF_WR_VALID <= 1'b0;
      BUF_WR_DATA  <= 8'h00;
      for (int i = 0; i < 7; i++) begin
        words_q[i] <= 16'h0000;
      end
    end else begin
      unique case (state_q)
        mif_pkg::MIF_SER_IDLE: begin
          BUF_WR_VALID <= 1'b0;
          half_q       <= 1'b0;
          if (SAMPLE_STROBE) begin
            words_q[0] <= ACCEL_X;
            words_q[1] <= ACCEL_Y;
            words_q[2] <= ACCEL_Z;
            words_q[3] <= TEMP_DATA;
            words_q[4] <= GYRO_X;
            words_q[5] <= GYRO_Y;
            words_q[6] <= GYRO_Z;
            mask_q     <= {stream_sel_q[`MIF_SEL_GZ], stream_sel_q[`MIF_SEL_GY],
                           stream_sel_q[`MIF_SEL_GX], stream_sel_q[`MIF_SEL_TEMP],
                           {3{stream_sel_q[`MIF_SEL_ACCEL]}}};
            state_q    <= mif_pkg::MIF_SER_EMIT;
          end
        end
        mif_pkg::MIF_SER_EMIT: begin
          if (mask_any) begin
            BUF_WR_VALID <= 1'b1;
            BUF_WR_DATA  <= half_q ? words_q[next_idx][7:0] : words_q[next_idx][15:8];
            half_q       <= ~half_q;
            if (half_q) begin
              mask_q[next_idx] <= 1'b0;
            end
          end else begin
            BUF_WR_VALID <= 1'b0;
            state_q      <= mif_pkg::MIF_SER_IDLE;
          end
        end
        default: state_q <= mif_pkg::MIF_SER_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// ---- test/mif_monitor.sv ----
// Purpose: Concurrent checks on the bus, buffer and pin ports of mif_top
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Attached to every mif_top by the bind at the foot
`timescale 1ns/1ps
`default_nettype none
module mif_monitor #(
  parameter int PULSE_CYC = 8
) (
  input wire logic        REF_CLK,
  input wire logic        RESET,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic        SAMPLE_STROBE,
  input wire logic        BUF_WR_VALID,
  input wire logic        IRQ_OUTPUT_PIN_O,
  input wire logic        IRQ_OUTPUT_PIN_OE
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RESET);
  a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
    |=> ##1 S_AXI_BVALID) else $error("write response missing");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID) else $error("read data missing");
  a_bresp_held: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  a_rdata_held: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  a_rdata_byte: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0) else $error("upper read bits set");
  a_aw_blocked: assert property (S_AXI_AWVALID && S_AXI_AWREADY |=> !S_AXI_AWREADY [*2]) else $error("aw reopened");
  a_ar_blocked: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> !S_AXI_ARREADY) else $error("ar reopened");
  a_drain_low: assert property (!IRQ_OUTPUT_PIN_OE |-> !IRQ_OUTPUT_PIN_O) else $error("released pin high");
  a_buf_first: assert property ($rose(BUF_WR_VALID) |-> $past(SAMPLE_STROBE, 2)) else $error("byte without sample");
  c_write: cover property (S_AXI_BVALID && S_AXI_BREADY);
  c_bytes: cover property (BUF_WR_VALID [*2]);
  c_drain: cover property (!IRQ_OUTPUT_PIN_OE);
endmodule
bind mif_top mif_monitor #(.PULSE_CYC(PULSE_CYC)) u_mon (.*);
`default_nettype wire

// ---- test/mif_host.sv ----
// Purpose: Host side of the interrupt line
// Assumes: Board pull-up on the line
// Notes:   Open drain relies on the pull-up for the high level
`timescale 1ns/1ps
`default_nettype none
module mif_host (
  input  wire logic drv_val,
  input  wire logic drv_en,
  output logic      pin_level
);
  // Undriven line floats up, never to a remembered value
  assign pin_level = drv_en ? drv_val : 1'b1;
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// Purpose: Self-checking bench for the motion interrupt block
// Assumes: Registers at four times their index, one byte per word
// Notes:   Short pulse count keeps the run brief
`timescale 1ns/1ps
`default_nettype none
`include "mif_cfg.svh"
module testbench;
  localparam int PC = 8;
  localparam logic [7:0] AL [10] = '{8'h80, 8'h84, 8'h88, 8'h8C, 8'hD8, 8'hDC, 8'hE0, 8'hE4, 8'hE8, 8'hFC};
  logic         REF_CLK = 1'b0, RESET = 1'b1, SAMPLE_STROBE = 1'b0, FRAME_SYNC_INPUT = 1'b0;
  logic [7:0]   S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
  logic [31:0]  S_AXI_WDATA = 32'h0;
  logic [3:0]   S_AXI_WSTRB = 4'hF;
  logic         S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
  logic         S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
  logic         BUF_OVERFLOW = 1'b0, GYRO_DRIVE_READY = 1'b0;
  logic [5:0]   MOTION_PROCESSOR_EVENTS = 6'h00;
  logic [15:0]  ACCEL_X = 16'h0, ACCEL_Y = 16'h0, ACCEL_Z = 16'h0, TEMP_DATA = 16'h0;
  logic [15:0]  GYRO_X = 16'h0, GYRO_Y = 16'h0, GYRO_Z = 16'h0;
  logic         S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic         BUF_WR_VALID, IRQ_OUTPUT_PIN_O, IRQ_OUTPUT_PIN_OE, lvl;
  logic [1:0]   S_AXI_BRESP, S_AXI_RRESP;
  logic [31:0]  S_AXI_RDATA;
  logic [7:0]   BUF_WR_DATA, x;
  logic [7:0]   m [64] = '{default: 8'h00};
  logic [7:0]   eq[$], gq[$];
  logic [15:0]  pv [3];
  logic [111:0] v;
  logic         pok = 1'b0;
  int           seed = 45, error_cnt = 0, checks_done = 0, hcnt = 0;
  mif_top #(.PULSE_CYC(PC)) DUT (.*);
  mif_host u_host (.drv_val(IRQ_OUTPUT_PIN_O), .drv_en(IRQ_OUTPUT_PIN_OE), .pin_level(lvl));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [7:0] msk(input logic [7:0] a);
    msk = (a inside {8'h80, 8'h84, 8'h88, 8'hE0}) ? 8'hFF : a == 8'h8C ? 8'hF8 : a == 8'hDC ? 8'hFC : 8'h00;
  endfunction
  function automatic logic [1:0] rsp(input logic [7:0] a);
    rsp = (a[1:0] == 2'h0 && a[7:2] inside {[6'h20:6'h23], [6'h36:6'h3A]}) ? `MIF_RESP_OKAY : `MIF_RESP_SLVERR;
  endfunction
  task automatic wrc(input logic [7:0] a, input logic [7:0] d);
    @(posedge REF_CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= {24'h0, d};
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do begin
      @(posedge REF_CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (S_AXI_BVALID !== 1'b1);
    S_AXI_BREADY <= 1'b0;
    chk("bresp", rsp(a), S_AXI_BRESP);
    // Lane zero carries the whole register; without it the write is dropped
    if (S_AXI_WSTRB[0]) m[a[7:2]] = (m[a[7:2]] & ~msk(a)) | (d & msk(a));
  endtask
  task automatic rdc(input logic [7:0] a);
    @(posedge REF_CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do begin
      @(posedge REF_CLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (S_AXI_RVALID !== 1'b1);
    S_AXI_RREADY <= 1'b0;
    chk("rresp", rsp(a), S_AXI_RRESP);
    chk($sformatf("reg %h", a), {24'h0, m[a[7:2]]}, S_AXI_RDATA);
    if (a inside {8'hD8, 8'hE4, 8'hE8}) m[a[7:2]] = 8'h00;
    if (m[6'h37][`MIF_PIN_RDCLR]) begin
      m[6'h36] = 8'h00;
      m[6'h39] = 8'h00;
      m[6'h3A] = 8'h00;
    end
  endtask
  task automatic smp(input logic [111:0] s);
    logic [15:0] w;
    int d;
    @(posedge REF_CLK);
    SAMPLE_STROBE <= 1'b1;
    {ACCEL_X, ACCEL_Y, ACCEL_Z, TEMP_DATA, GYRO_X, GYRO_Y, GYRO_Z} <= s;
    @(posedge REF_CLK);
    SAMPLE_STROBE <= 1'b0;
    m[6'h3A][0] = 1'b1;
    for (int k = 0; k < 7; k++) begin
      w = s[111 - 16 * k -: 16];
      if (m[6'h23][k < 3 ? 3 : k == 3 ? 7 : 10 - k]) begin
        eq.push_back(w[15:8]);
        eq.push_back(w[7:0]);
      end
      if (k < 3) begin
        d = $signed(w) - $signed(pv[k]);
        d = d < 0 ? -d : d;
        if (pok && m[6'h38][7:5] == 3'h7 && d > int'(m[6'h20 + k])) m[6'h3A][7:5] = 3'h7;
        pv[k] = w;
      end
    end
    pok = 1'b1;
    // Longest frame is 14 bytes, so 20 cycles always drain it
    repeat (20) @(posedge REF_CLK);
    chk("byte count", eq.size(), gq.size());
    while (eq.size() > 0 && gq.size() > 0) chk("byte", eq.pop_front(), gq.pop_front());
    eq = {};
    gq = {};
  endtask
  task automatic ev(input logic [7:0] e);
    @(posedge REF_CLK);
    {MOTION_PROCESSOR_EVENTS, GYRO_DRIVE_READY, BUF_OVERFLOW} <= e;
    @(posedge REF_CLK);
    {MOTION_PROCESSOR_EVENTS, GYRO_DRIVE_READY, BUF_OVERFLOW} <= 8'h00;
    m[6'h3A] = m[6'h3A] | {3'h0, e[0], 1'b0, e[1], |e[7:2], 1'b0};
    m[6'h39] = m[6'h39] | {2'h0, e[7:2]};
  endtask
  task automatic pin(input logic a);
    repeat (3) @(posedge REF_CLK);
    chk("pin", {31'h0, a ^ m[6'h37][`MIF_PIN_POL]}, {31'h0, lvl});
  endtask
  task automatic give_verdict();
    if (error_cnt == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial forever #10 REF_CLK = ~REF_CLK;
  always @(posedge REF_CLK) begin
    if (BUF_WR_VALID === 1'b1) gq.push_back(BUF_WR_DATA);
    if (lvl === 1'b1) hcnt <= hcnt + 1;
  end
  initial begin
    repeat (20000) @(posedge REF_CLK);
    error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (2) @(posedge REF_CLK);
    RESET <= 1'b0;
    foreach (AL[i]) rdc(AL[i]);
    foreach (AL[i]) begin
      x = 8'($random(seed)) & (AL[i] == 8'hDC ? 8'hF3 : AL[i] < 8'h8C ? 8'h1F : 8'hFF);
      wrc(AL[i], x);
      rdc(AL[i]);
    end
    wrc(8'hDC, 8'h00);
    S_AXI_WSTRB <= 4'hE;
    wrc(8'h80, 8'h55);
    S_AXI_WSTRB <= 4'hF;
    rdc(8'h80);
    for (int i = 0; i < 6; i++) begin
      x = 8'($random(seed));
      wrc(8'h8C, i == 0 ? 8'h00 : i == 1 ? 8'hFF : x);
      wrc(8'hE0, i % 3 == 2 ? x : {3'h7, x[4:0]});
      v = 112'({$random(seed), $random(seed), $random(seed), $random(seed)});
      for (int k = 0; k < 3; k++) v[111 - 16 * k -: 16] = 16'($random(seed) % 40);
      smp(v);
      rdc(8'hE8);
    end
    wrc(8'hE0, 8'h00);
    wrc(8'hDC, 8'h20);
    ev(8'h01);
    pin(1'b0);
    wrc(8'hE0, 8'h10);
    pin(1'b1);
    rdc(8'hE8);
    pin(1'b0);
    wrc(8'hDC, 8'hE0);
    wrc(8'hE0, 8'h04);
    pin(1'b0);
    ev(8'h02);
    pin(1'b1);
    rdc(8'hE8);
    wrc(8'hDC, 8'h30);
    wrc(8'hE0, 8'h02);
    ev(8'hA8);
    pin(1'b1);
    rdc(8'h80);
    pin(1'b0);
    rdc(8'hE4);
    wrc(8'hDC, 8'h20);
    ev(8'hFC);
    rdc(8'hE4);
    rdc(8'hE4);
    rdc(8'hE8);
    wrc(8'hDC, 8'h00);
    wrc(8'hE0, 8'h01);
    wrc(8'h8C, 8'h00);
    hcnt = 0;
    smp(v);
    chk("pulse", PC, hcnt);
    rdc(8'hE8);
    for (int p = 0; p < 4; p++) begin
      wrc(8'hDC, 8'h00);
      FRAME_SYNC_INPUT <= p[1];
      wrc(8'hDC, {4'h0, p[1], p[0], 2'h0});
      FRAME_SYNC_INPUT <= ~p[1];
      repeat (4) @(posedge REF_CLK);
      m[6'h36] = {p[0], 7'h00};
      rdc(8'hD8);
      rdc(8'hD8);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
